// file: hw/fan_ramp_pkg.sv
// shared types and constants for the fan duty ramp and floor block
// assumes a 200 MHz single clock and a byte-wide register port
package fan_ramp_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_MODE_CTRL   = 8'h01; // lock, auto mode, floor selects
  localparam logic [7:0] ADDR_CONFIG_SIX  = 8'h10;
  localparam logic [7:0] ADDR_SMOOTH_B    = 8'h63; // acoustic_smoothing_ctrl_b
  localparam logic [7:0] ADDR_OUT1_MIN    = 8'h64;
  localparam logic [7:0] ADDR_OUT2_MIN    = 8'h65;
  localparam logic [7:0] ADDR_OUT3_MIN    = 8'h66;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int         LOCAL_RATE_LSB   = 0;     // local_ramp_rate [2:0]
  localparam int         LOCAL_EN_BIT     = 3;     // local_smooth_enable
  localparam int         REMB_RATE_LSB    = 4;     // remote_b_ramp_rate [6:4]
  localparam int         REMB_EN_BIT      = 7;     // remote_b_smooth_enable
  localparam int         SLOT_LONG_BIT    = 7;     // config six: longer time slot
  localparam int         SLOW_LOCAL_BIT   = 1;     // config six: local ramp / 4
  localparam int         SLOW_REMB_BIT    = 2;     // config six: remote b ramp / 4
  localparam int         LOCK_BIT         = 0;
  localparam int         AUTO_BIT         = 1;
  localparam int         FLOOR_SEL_LSB    = 2;     // out1..out3 floor select [4:2]
  localparam logic [7:0] SMOOTH_RESET     = 8'h00;
  localparam logic [7:0] MIN_DUTY_RESET   = 8'h80; // half duty
  localparam logic [7:0] CTRL_RESET       = 8'h00;
  localparam logic [7:0] DUTY_OFF         = 8'h00;
  localparam logic [1:0] SLOW_DIV_LAST    = 2'h3;  // quarter rate: every fourth slot

  // steps per slot for ramp codes 000..111
  localparam logic [7:0][5:0] RAMP_STEP_TABLE = {6'h30, 6'h18, 6'h0c, 6'h08,
                                                 6'h04, 6'h03, 6'h02, 6'h01};

  // ----------------------------------------------------------------
  // timing: full sweep with step 1 spans 256 slots
  // ----------------------------------------------------------------
  localparam longint SWEEP_SHORT_MS     = 37500;   // 37.5 s
  localparam longint SWEEP_LONG_MS      = 52200;   // 52.2 s
  localparam longint CYCLES_PER_MS      = 200000;  // 200 MHz
  localparam longint DUTY_SPAN          = 256;
  localparam int     SLOT_SHORT_CYCLES  = int'(SWEEP_SHORT_MS * CYCLES_PER_MS / DUTY_SPAN);
  localparam int     SLOT_LONG_CYCLES   = int'(SWEEP_LONG_MS * CYCLES_PER_MS / DUTY_SPAN);

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {CH_REMOTE_A, CH_LOCAL, CH_REMOTE_B} channel_type;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wrData;
    logic       wrStrobe;
    logic       rdStrobe;
  } reg_req_type;

  typedef struct packed {
    logic [7:0]  target;   // duty computed by the control loop
    logic        below;    // temperature under threshold minus hysteresis
    channel_type channel;  // controlling temperature channel
  } out_req_type;

  typedef struct packed {
    logic [7:0]      ctrl;
    logic [7:0]      configSix;
    logic [7:0]      smooth;
    logic [2:0][7:0] minDuty;
    logic [2:0][7:0] duty;
    logic [31:0]     slotCnt;
    logic [1:0][1:0] divCnt;    // [0] local, [1] remote b
    logic [7:0]      rdData;
  } fan_ramp_state_type;

endpackage

// file: hw/fan_pwm_ramp.sv
// duty ramp limiter and minimum-duty floor for three fan outputs
// assumes the control loop supplies targets on clk; register port is same-clock
//
// What this block does
// [R01] lock bit makes smoothing register read-only
// [R02] slow bit divides channel ramp rate by four
// [R03] bits 2:0 limit local channel duty slope
// [R04] codes give steps 1..48, short time slot
// [R05] config six bit 7 selects longer slot
// [R06] bit 3 enables local smoothing, else immediate
// [R07] bits 6:4 limit remote b duty slope
// [R08] bit 7 enables remote b smoothing
// [R09] three 8-bit minimum duty registers
// [R10] floor duty linear in register value
// [R11] minimum duty resets to half duty
// [R12] auto mode makes minimum duty read-only
// [R13] smoothing register resets to zero
// [R14] floor select: below threshold gives off or minimum
// [R15] above threshold duty starts at minimum
// [R16] each slot moves duty by step, no overshoot
// [R17] smoothing off applies target next update
module fan_pwm_ramp #(
  parameter int unsigned SLOT_SHORT = fan_ramp_pkg::SLOT_SHORT_CYCLES,
  parameter int unsigned SLOT_LONG  = fan_ramp_pkg::SLOT_LONG_CYCLES
) (
  // clock and reset
  input  wire logic                       clk,
  input  wire logic                       nrst,
  // register port
  input  wire fan_ramp_pkg::reg_req_type  regReq,
  output logic [7:0]                      rdData,
  // per-output requests from the control loop
  input  wire fan_ramp_pkg::out_req_type  outReq [3],
  // fan drive duties and auto mode flag
  output logic [2:0][7:0]                 fanDriveOutput,
  output logic                            autoMode
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  fan_ramp_pkg::fan_ramp_state_type state_reg;
  fan_ramp_pkg::fan_ramp_state_type state_next;

  logic        locked;
  logic        slotTick;
  logic [31:0] slotLast;
  logic [1:0]  chanTick;      // [0] local, [1] remote b
  logic [1:0]  chanEnable;
  logic [1:0]  chanSlow;
  logic [1:0][5:0] chanStep;
  logic [2:0][7:0] effTarget;
  logic [2:0]      rampOut;
  logic [2:0]      outTick;
  logic [2:0][5:0] outStep;

  assign locked   = state_reg.ctrl[fan_ramp_pkg::LOCK_BIT];
  assign autoMode = state_reg.ctrl[fan_ramp_pkg::AUTO_BIT];

  // ----------------------------------------------------------------
  // slot timing and channel decode
  // ----------------------------------------------------------------
  // slot length from config six bit 7
  assign slotLast = state_reg.configSix[fan_ramp_pkg::SLOT_LONG_BIT] ?
                    32'(SLOT_LONG - 1) : 32'(SLOT_SHORT - 1); // R04 R05
  // >= so that a shorter slot chosen mid-count cannot strand the counter
  assign slotTick = (state_reg.slotCnt >= slotLast);

  // channel settings; index 0 local, 1 remote b
  always_comb begin
    chanEnable[0] = state_reg.smooth[fan_ramp_pkg::LOCAL_EN_BIT];     // R06
    chanEnable[1] = state_reg.smooth[fan_ramp_pkg::REMB_EN_BIT];      // R08
    chanStep[0]   = fan_ramp_pkg::RAMP_STEP_TABLE[
                      state_reg.smooth[fan_ramp_pkg::LOCAL_RATE_LSB +: 3]]; // R03
    chanStep[1]   = fan_ramp_pkg::RAMP_STEP_TABLE[
                      state_reg.smooth[fan_ramp_pkg::REMB_RATE_LSB +: 3]];  // R07
    chanSlow[0]   = state_reg.configSix[fan_ramp_pkg::SLOW_LOCAL_BIT];
    chanSlow[1]   = state_reg.configSix[fan_ramp_pkg::SLOW_REMB_BIT];
  end

  // a slow channel only acts on every fourth slot
  genvar c;
  generate
    for (c = 0; c < 2; c++) begin : g_chan
      assign chanTick[c] = slotTick &&
                           (!chanSlow[c] ||
                            state_reg.divCnt[c] == fan_ramp_pkg::SLOW_DIV_LAST); // R02
    end
  endgenerate

  // ----------------------------------------------------------------
  // per-output target, floor and ramp selection
  // ----------------------------------------------------------------
  genvar o;
  generate
    for (o = 0; o < 3; o++) begin : g_out
      // below threshold: off or floor; above: never under the floor
      always_comb begin
        if (outReq[o].below) begin
          effTarget[o] = state_reg.ctrl[fan_ramp_pkg::FLOOR_SEL_LSB + o] ?
                         state_reg.minDuty[o] : fan_ramp_pkg::DUTY_OFF; // R14 R10
        end else if (outReq[o].target < state_reg.minDuty[o]) begin
          effTarget[o] = state_reg.minDuty[o]; // R15
        end else begin
          effTarget[o] = outReq[o].target;
        end
        unique case (outReq[o].channel)
          fan_ramp_pkg::CH_LOCAL: begin
            rampOut[o] = chanEnable[0];
            outTick[o] = chanTick[0];
            outStep[o] = chanStep[0];
          end
          fan_ramp_pkg::CH_REMOTE_B: begin
            rampOut[o] = chanEnable[1];
            outTick[o] = chanTick[1];
            outStep[o] = chanStep[1];
          end
          default: begin
            // remote a smoothing lives elsewhere; illegal code also lands here
            rampOut[o] = 1'b0;
            outTick[o] = 1'b0;
            outStep[o] = 6'h00;
          end
        endcase
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [7:0] gap;
    logic [7:0] stepWide;
    logic       wr;
    gap        = 8'h00;
    stepWide   = 8'h00;
    wr         = regReq.wrStrobe;
    state_next = state_reg;

    // slot counter runs freely
    state_next.slotCnt = slotTick ? 32'h0 : state_reg.slotCnt + 32'h1;
    for (int k = 0; k < 2; k++) begin
      if (slotTick) begin
        state_next.divCnt[k] = state_reg.divCnt[k] + 2'h1;
      end
    end

    // register writes with their guards
    if (wr && regReq.addr == fan_ramp_pkg::ADDR_MODE_CTRL) begin
      if (locked) begin
        state_next.ctrl = state_reg.ctrl; // lock cannot be undone
      end else begin
        state_next.ctrl = regReq.wrData;
      end
    end
    if (wr && regReq.addr == fan_ramp_pkg::ADDR_CONFIG_SIX && !locked) begin
      state_next.configSix = regReq.wrData;
    end
    if (wr && regReq.addr == fan_ramp_pkg::ADDR_SMOOTH_B && !locked) begin // R01
      state_next.smooth = regReq.wrData;
    end
    for (int k = 0; k < 3; k++) begin
      if (wr && !autoMode &&
          regReq.addr == fan_ramp_pkg::ADDR_OUT1_MIN + 8'(k)) begin // R09 R12
        state_next.minDuty[k] = regReq.wrData;
      end
    end

    // duty update per output
    for (int k = 0; k < 3; k++) begin
      stepWide = {2'h0, outStep[k]};
      if (!autoMode) begin
        state_next.duty[k] = outReq[k].target; // manual: no floor, no ramp
      end else if (!rampOut[k]) begin
        state_next.duty[k] = effTarget[k]; // R17 R06
      end else if (outTick[k]) begin
        // step toward target, clipped at the target
        if (state_reg.duty[k] < effTarget[k]) begin
          gap = effTarget[k] - state_reg.duty[k];
          state_next.duty[k] = (gap > stepWide) ? state_reg.duty[k] + stepWide
                                                : effTarget[k]; // R16 R04
        end else begin
          gap = state_reg.duty[k] - effTarget[k];
          state_next.duty[k] = (gap > stepWide) ? state_reg.duty[k] - stepWide
                                                : effTarget[k]; // R16
        end
      end
    end

    // read data stands one cycle only
    state_next.rdData = 8'h00;
    if (regReq.rdStrobe) begin
      unique case (regReq.addr)
        fan_ramp_pkg::ADDR_MODE_CTRL:  state_next.rdData = state_reg.ctrl;
        fan_ramp_pkg::ADDR_CONFIG_SIX: state_next.rdData = state_reg.configSix;
        fan_ramp_pkg::ADDR_SMOOTH_B:   state_next.rdData = state_reg.smooth;
        fan_ramp_pkg::ADDR_OUT1_MIN:   state_next.rdData = state_reg.minDuty[0];
        fan_ramp_pkg::ADDR_OUT2_MIN:   state_next.rdData = state_reg.minDuty[1];
        fan_ramp_pkg::ADDR_OUT3_MIN:   state_next.rdData = state_reg.minDuty[2];
        default:                       state_next.rdData = 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_reg.ctrl      <= fan_ramp_pkg::CTRL_RESET;
      state_reg.configSix <= fan_ramp_pkg::SMOOTH_RESET;
      state_reg.smooth    <= fan_ramp_pkg::SMOOTH_RESET;  // R13
      for (int k = 0; k < 3; k++) begin
        state_reg.minDuty[k] <= fan_ramp_pkg::MIN_DUTY_RESET; // R11
        state_reg.duty[k]    <= fan_ramp_pkg::DUTY_OFF;
      end
      state_reg.slotCnt   <= 32'h0;
      state_reg.divCnt    <= 4'h0;
      state_reg.rdData    <= 8'h00;
    end else begin
      state_reg <= state_next;
    end
  end

  assign rdData         = state_reg.rdData;
  assign fanDriveOutput = state_reg.duty;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  lock_blocks_a: assert property (@(posedge clk) disable iff (!nrst)
    locked && regReq.wrStrobe && regReq.addr == fan_ramp_pkg::ADDR_SMOOTH_B
    |=> $stable(state_reg.smooth))
    else $error("smoothing register changed while locked"); // R01

  smooth_reset_a: assert property (@(posedge clk)
    $rose(nrst) |-> state_reg.smooth == fan_ramp_pkg::SMOOTH_RESET)
    else $error("smoothing register not zero after reset"); // R13

  min_reset_a: assert property (@(posedge clk)
    $rose(nrst) |-> state_reg.minDuty[0] == fan_ramp_pkg::MIN_DUTY_RESET &&
                    state_reg.minDuty[2] == fan_ramp_pkg::MIN_DUTY_RESET)
    else $error("minimum duty not half after reset"); // R11

  auto_readonly_a: assert property (@(posedge clk) disable iff (!nrst)
    autoMode && regReq.wrStrobe && regReq.addr == fan_ramp_pkg::ADDR_OUT2_MIN
    |=> $stable(state_reg.minDuty[1]))
    else $error("minimum duty written in auto mode"); // R12

  min_readback_a: assert property (@(posedge clk) disable iff (!nrst)
    regReq.rdStrobe && regReq.addr == fan_ramp_pkg::ADDR_OUT1_MIN
    |=> rdData == $past(state_reg.minDuty[0]) ##1 (rdData == 8'h00 || $past(regReq.rdStrobe)))
    else $error("minimum duty readback wrong"); // R09

  slow_divide_a: assert property (@(posedge clk) disable iff (!nrst)
    chanTick[0] && chanSlow[0] |-> state_reg.divCnt[0] == fan_ramp_pkg::SLOW_DIV_LAST)
    else $error("slow local ramp acted off its fourth slot"); // R02

  hold_between_a: assert property (@(posedge clk) disable iff (!nrst)
    autoMode && outReq[0].channel == fan_ramp_pkg::CH_LOCAL && chanEnable[0] &&
    !chanTick[0] |=> state_reg.duty[0] == $past(state_reg.duty[0]))
    else $error("local ramp moved between slots"); // R06

  step_size_a: assert property (@(posedge clk) disable iff (!nrst)
    autoMode && outReq[0].channel == fan_ramp_pkg::CH_LOCAL && chanEnable[0] &&
    chanTick[0] && {1'b0, effTarget[0]} > {1'b0, state_reg.duty[0]} + 9'(chanStep[0])
    |=> state_reg.duty[0] == $past(state_reg.duty[0]) + 8'($past(chanStep[0])))
    else $error("ramp step differs from coded step"); // R04

  no_overshoot_a: assert property (@(posedge clk) disable iff (!nrst)
    autoMode && rampOut[2] && state_reg.duty[2] <= effTarget[2]
    |=> state_reg.duty[2] <= $past(effTarget[2]))
    else $error("ramp overshot its target"); // R16

  direct_apply_a: assert property (@(posedge clk) disable iff (!nrst)
    autoMode && !rampOut[2] |=> state_reg.duty[2] == $past(effTarget[2]))
    else $error("unsmoothed duty not applied next cycle"); // R17

  floor_off_a: assert property (@(posedge clk) disable iff (!nrst)
    autoMode && !rampOut[1] && outReq[1].below &&
    !state_reg.ctrl[fan_ramp_pkg::FLOOR_SEL_LSB + 1] |=> state_reg.duty[1] == 8'h00)
    else $error("output not off below threshold"); // R14

  floor_min_a: assert property (@(posedge clk) disable iff (!nrst)
    autoMode && !rampOut[1] && !outReq[1].below
    |=> state_reg.duty[1] >= $past(state_reg.minDuty[1]))
    else $error("duty under floor above threshold"); // R15

  // ----------------------------------------------------------------
  // checks on lock, slot timing, remote b ramp, register port, floor select and remote a
  // ----------------------------------------------------------------
  config_lock_a: assert property (@(posedge clk) disable iff (!nrst) // R01
    locked && regReq.wrStrobe && regReq.addr == fan_ramp_pkg::ADDR_CONFIG_SIX
    |=> $stable(state_reg.configSix))
    else $error("config six changed while locked");

  lock_sticky_a: assert property (@(posedge clk) disable iff (!nrst) // R01
    locked |=> locked)
    else $error("lock bit cleared without reset");

  remb_slow_a: assert property (@(posedge clk) disable iff (!nrst) // R02
    chanTick[1] && chanSlow[1] |-> state_reg.divCnt[1] == fan_ramp_pkg::SLOW_DIV_LAST)
    else $error("slow remote b ramp acted off its fourth slot");

  slot_wrap_a: assert property (@(posedge clk) disable iff (!nrst) // R04
    slotTick |=> state_reg.slotCnt == 32'h0)
    else $error("slot counter did not restart");

  remb_down_a: assert property (@(posedge clk) disable iff (!nrst) // R07
    autoMode && rampOut[2] && outTick[2] &&
    {1'b0, state_reg.duty[2]} > {1'b0, effTarget[2]} + 9'(outStep[2])
    |=> state_reg.duty[2] == $past(state_reg.duty[2]) - 8'($past(outStep[2])))
    else $error("remote b step down differs from coded step");

  remb_hold_a: assert property (@(posedge clk) disable iff (!nrst) // R08
    autoMode && rampOut[2] && !outTick[2] |=> $stable(state_reg.duty[2]))
    else $error("remote b ramp moved between slots");

  min_write_a: assert property (@(posedge clk) disable iff (!nrst) // R09
    !autoMode && regReq.wrStrobe && regReq.addr == fan_ramp_pkg::ADDR_OUT3_MIN
    |=> state_reg.minDuty[2] == $past(regReq.wrData))
    else $error("minimum duty write lost in manual mode");

  read_idle_a: assert property (@(posedge clk) disable iff (!nrst) // R09
    !regReq.rdStrobe |=> rdData == 8'h00)
    else $error("read data stood without a read");

  floor_hold_a: assert property (@(posedge clk) disable iff (!nrst) // R14
    autoMode && !rampOut[0] && outReq[0].below &&
    state_reg.ctrl[fan_ramp_pkg::FLOOR_SEL_LSB] |=> state_reg.duty[0] == $past(state_reg.minDuty[0]))
    else $error("output not at floor below threshold");

  remote_a_direct_a: assert property (@(posedge clk) disable iff (!nrst) // R17
    autoMode && outReq[1].channel == fan_ramp_pkg::CH_REMOTE_A
    |=> state_reg.duty[1] == $past(effTarget[1]))
    else $error("remote a output not applied directly");

endmodule

// file: verif/fan_load_model.sv
// behavioural fan load hanging on the three duty outputs
// assumes duty is a registered level on clk; speed is only a rough figure
module fan_load_model (
  // clock and reset
  input  wire logic            clk,
  input  wire logic            nrst,
  // duty from the ramp block
  input  wire logic [2:0][7:0] duty,
  // spin estimate per fan
  output logic      [2:0][7:0] speed
);
  timeunit 1ns;
  timeprecision 100ps;

  // ------------------------------------------------------------
  // rotor inertia
  // ------------------------------------------------------------
  // one count per cycle: a fan cannot follow a duty jump at once
  always_ff @(posedge clk) begin
    for (int k = 0; k < 3; k++) begin
      if (!nrst) begin
        speed[k] <= 8'h00;
      end else if (speed[k] < duty[k]) begin
        speed[k] <= speed[k] + 8'h01;
      end else if (speed[k] > duty[k]) begin
        speed[k] <= speed[k] - 8'h01;
      end
    end
  end
endmodule

// file: verif/fan_pwm_ramp_and_min_duty_test.sv
// self-checking bench for the fan duty ramp and floor block
// assumes short slots of 4 and 6 cycles so that ramps finish quickly
`define CHK(got, exp) begin samplesChecked++; if ((got) !== (exp)) begin mismatches++; \
  $display("BAD t=%0t got=%h exp=%h", $time, got, exp); end end

module fan_pwm_ramp_and_min_duty_test;
  timeunit 1ns;
  timeprecision 100ps;

  typedef struct packed {
    logic [1:0] src;  // 0..2 fan output, 3 read data
    logic [7:0] val;
  } note_type;

  logic                      clk;
  logic                      nrst;
  fan_ramp_pkg::reg_req_type regReq;
  logic [7:0]                rdData;
  fan_ramp_pkg::out_req_type outReq [3];
  logic [2:0][7:0]           fanDriveOutput;
  logic                      autoMode;
  logic [2:0][7:0]           fanSpeed;
  note_type                  notes[$];
  note_type                  n;
  int                        mismatches;
  int                        samplesChecked;
  logic [7:0]                minDuty [3];
  logic [7:0]                tgt;
  int                        steps [8] = '{1, 2, 3, 4, 8, 12, 24, 48};

  fan_pwm_ramp #(.SLOT_SHORT(4), .SLOT_LONG(6)) fan_pwm_ramp_inst (
    .clk(clk), .nrst(nrst), .regReq(regReq), .rdData(rdData), .outReq(outReq),
    .fanDriveOutput(fanDriveOutput), .autoMode(autoMode));

  fan_load_model fan_load_model_inst (
    .clk(clk), .nrst(nrst), .duty(fanDriveOutput), .speed(fanSpeed));

  // ------------------------------------------------------------
  // clock, watchdog, monitor
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // all scenarios together need well under 4000 cycles
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    conclude();
  end

  // results are compared mid-cycle, where every output has settled
  always @(negedge clk) begin
    if (notes.size() > 0) begin
      n = notes.pop_front();
      if (n.src == 2'h3) `CHK(rdData, n.val)
      else `CHK(fanDriveOutput[n.src], n.val)
    end
  end

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regReq <= '{addr: a, wrData: d, wrStrobe: 1'b1, rdStrobe: 1'b0};
    @(posedge clk);
    regReq.wrStrobe <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    regReq <= '{addr: a, wrData: 8'h00, wrStrobe: 1'b0, rdStrobe: 1'b1};
    @(posedge clk);
    regReq.rdStrobe <= 1'b0;
    notes.push_back('{src: 2'h3, val: exp});
  endtask

  task automatic expectOut(input int k, input logic [7:0] v);
    @(posedge clk);
    notes.push_back('{src: k[1:0], val: v});
  endtask

  // each step must be exact, gaps between steps gap cycles, no overshoot
  task automatic ramp(input int k, input int step, input int gap, input logic [7:0] t);
    int cur;
    int nxt;
    int cyc;
    int last;
    #1;
    cur = int'(fanDriveOutput[k]);
    last = -1;
    cyc = 0;
    for (int i = 0; i < 3000 && cur != int'(t); i++) begin
      @(posedge clk);
      #1;
      cyc++;
      if (fanDriveOutput[k] !== cur[7:0]) begin
        nxt = (cur > t) ? ((cur - t > step) ? cur - step : t) :
                          ((t - cur > step) ? cur + step : t);
        notes.push_back('{src: k[1:0], val: nxt[7:0]});
        if (last >= 0) `CHK(cyc - last, gap)
        last = cyc;
        cur = nxt;
      end
    end
    `CHK(fanDriveOutput[k], t)
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", samplesChecked, mismatches);
    if (mismatches == 0 && samplesChecked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    nrst = 1'b0;
    regReq = '0;
    outReq[0] = '{target: 8'h00, below: 1'b0, channel: fan_ramp_pkg::CH_LOCAL};
    outReq[1] = '{target: 8'h00, below: 1'b0, channel: fan_ramp_pkg::CH_REMOTE_A};
    outReq[2] = '{target: 8'h00, below: 1'b0, channel: fan_ramp_pkg::CH_REMOTE_B};
    mismatches = 0;
    samplesChecked = 0;
    void'($urandom(89));
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    rd(fan_ramp_pkg::ADDR_SMOOTH_B, 8'h00);
    for (int k = 0; k < 3; k++) rd(8'h64 + k[7:0], 8'h80);
    rd(8'h7f, 8'h00);
    // floors written in manual mode, then read back
    minDuty[0] = 8'($urandom_range(0, 31));
    minDuty[1] = 8'($urandom_range(16, 255));
    minDuty[2] = 8'h40;
    for (int k = 0; k < 3; k++) wr(8'h64 + k[7:0], minDuty[k]);
    for (int k = 0; k < 3; k++) rd(8'h64 + k[7:0], minDuty[k]);
    // auto mode, output 1 holds its floor below threshold, output 2 goes off
    wr(fan_ramp_pkg::ADDR_MODE_CTRL, 8'h06);
    #1 `CHK(autoMode, 1'b1)
    wr(fan_ramp_pkg::ADDR_OUT1_MIN, ~minDuty[0]);
    rd(fan_ramp_pkg::ADDR_OUT1_MIN, minDuty[0]);
    @(posedge clk);
    outReq[0].below <= 1'b1;
    outReq[1].below <= 1'b1;
    expectOut(0, minDuty[0]);
    expectOut(1, 8'h00);
    @(posedge clk);
    outReq[0].below <= 1'b0;
    outReq[1].below <= 1'b0;
    outReq[0].target <= 8'h25;
    outReq[1].target <= minDuty[1] - 8'h01;
    expectOut(0, 8'h25);
    expectOut(1, minDuty[1]);
    // every local ramp code, alternating up and down
    for (int c = 0; c < 8; c++) begin
      wr(fan_ramp_pkg::ADDR_SMOOTH_B, {4'h0, 1'b1, c[2:0]});
      tgt = c[0] ? 8'h20 : 8'h40 + 8'($urandom_range(0, 63));
      @(posedge clk);
      outReq[0].target <= tgt;
      ramp(0, steps[c], 4, tgt);
    end
    // remote b at quarter rate, then long slot with the largest step
    wr(fan_ramp_pkg::ADDR_CONFIG_SIX, 8'h04);
    wr(fan_ramp_pkg::ADDR_SMOOTH_B, 8'hb0);
    @(posedge clk);
    outReq[2].target <= 8'hc0;
    ramp(2, 4, 16, 8'hc0);
    wr(fan_ramp_pkg::ADDR_CONFIG_SIX, 8'h80);
    wr(fan_ramp_pkg::ADDR_SMOOTH_B, 8'hf0);
    @(posedge clk);
    outReq[2].target <= 8'h00;
    ramp(2, 48, 6, minDuty[2]);
    // lock: smoothing register and mode register freeze
    wr(fan_ramp_pkg::ADDR_MODE_CTRL, 8'h07);
    wr(fan_ramp_pkg::ADDR_SMOOTH_B, 8'h0b);
    rd(fan_ramp_pkg::ADDR_SMOOTH_B, 8'hf0);
    wr(fan_ramp_pkg::ADDR_MODE_CTRL, 8'h00);
    rd(fan_ramp_pkg::ADDR_MODE_CTRL, 8'h07);
    #1 `CHK(autoMode, 1'b1)
    // fans must have spun up or down to their settled duty by now
    repeat (200) @(posedge clk);
    #1;
    for (int k = 0; k < 3; k++) `CHK(fanSpeed[k], fanDriveOutput[k])
    conclude();
  end
endmodule
